// ==== logic/lcm_pkg.sv ====
/*
 * Shared constants and types of the layer, cursor and memory command logic.
 * Assumes an 8-bit host data path and 16-bit display memory addresses.
 */
package lcm_pkg;
    // Register offsets on the register port.
    localparam logic [15:0] OFS_STEP_DIR = 16'h8017;
    localparam logic [15:0] OFS_OVERLAY = 16'h8018;
    localparam logic [15:0] OFS_CG_LOW = 16'h8019;
    localparam logic [15:0] OFS_CG_HIGH = 16'h801a;
    localparam logic [15:0] OFS_DOT_SHIFT = 16'h801b;
    localparam logic [15:0] OFS_PTR_WR_LOW = 16'h801c;
    localparam logic [15:0] OFS_PTR_WR_HIGH = 16'h801d;
    localparam logic [15:0] OFS_PTR_RD_LOW = 16'h801e;
    localparam logic [15:0] OFS_PTR_RD_HIGH = 16'h801f;
    localparam logic [15:0] OFS_DEPTH = 16'h8020;
    localparam logic [15:0] OFS_PITCH_LOW = 16'h8021;
    localparam logic [15:0] OFS_PITCH_HIGH = 16'h8022;
    localparam logic [15:0] OFS_FLASH = 16'h8023;

    // Command bytes.
    localparam logic [7:0] CMD_SET_POINTER = 8'h46;
    localparam logic [7:0] CMD_READ_POINTER = 8'h47;
    localparam logic [7:0] CMD_MEMORY_WRITE = 8'h42;
    localparam logic [7:0] CMD_MEMORY_READ = 8'h43;
    localparam logic [7:0] CMD_OVERLAY = 8'h5b;
    localparam logic [7:0] CMD_GLYPH_RAM_OFFSET = 8'h5c;
    localparam logic [7:0] CMD_DOT_SHIFT = 8'h5a;
    localparam logic [7:0] CMD_PIXEL_DEPTH = 8'h60;
    localparam logic [5:0] CMD_DIR_BASE = 6'h13;

    // Field positions of the overlay register.
    localparam int OVL_LAYER_COUNT = 4;
    localparam int OVL_BLOCK3_MODE = 3;
    localparam int OVL_BLOCK1_MODE = 2;

    // Combine methods and special flash attribute values.
    localparam logic [1:0] MIX_OR = 2'h0;
    localparam logic [1:0] MIX_XOR = 2'h1;
    localparam logic [1:0] MIX_AND = 2'h2;
    localparam logic [1:0] MIX_PRIORITY = 2'h3;
    localparam logic [5:0] FLASH_BLANK_A = 6'h20;
    localparam logic [5:0] FLASH_BLANK_B = 6'h30;
    localparam logic [1:0] DEPTH_1BPP = 2'h0;

    // Values after reset.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_PITCH = 8'h28;

    typedef enum logic [1:0] {
        LCM_DIR_RIGHT = 2'b00,
        LCM_DIR_LEFT = 2'b01,
        LCM_DIR_UP = 2'b10,
        LCM_DIR_DOWN = 2'b11
    } lcm_dir_t;

    typedef enum logic [3:0] {
        LCM_CTX_NONE = 4'b0000,
        LCM_CTX_OVERLAY = 4'b0001,
        LCM_CTX_GLYPH = 4'b0010,
        LCM_CTX_SHIFT = 4'b0011,
        LCM_CTX_SET_PTR = 4'b0100,
        LCM_CTX_READ_PTR = 4'b0101,
        LCM_CTX_MEM_WRITE = 4'b0110,
        LCM_CTX_MEM_READ = 4'b0111,
        LCM_CTX_DEPTH = 4'b1000
    } lcm_ctx_t;
endpackage

// ==== logic/lcm_step.sv ====
/*
 * Next value of the memory pointer for one automatic step.
 * Assumes pointer, direction and pitch come from registers on the same clock.
 */
`timescale 1ns/1ps
module lcm_step (
    input wire logic [15:0] ptr,
    input wire logic [1:0] dir,
    input wire logic [15:0] pitch,
    output logic [15:0] next_ptr
);
    always_comb begin
        unique case (lcm_pkg::lcm_dir_t'(dir))
            lcm_pkg::LCM_DIR_RIGHT: next_ptr = ptr + 16'h0001;
            lcm_pkg::LCM_DIR_LEFT: next_ptr = ptr - 16'h0001;
            lcm_pkg::LCM_DIR_UP: next_ptr = ptr - pitch;
            lcm_pkg::LCM_DIR_DOWN: next_ptr = ptr + pitch;
        endcase
    end
endmodule

// ==== logic/lcm_compose.sv ====
/*
 * Combines up to three layer pixels into one pixel.
 * Assumes the flash phase input is a level from scan logic on the same clock.
 */
`timescale 1ns/1ps
module lcm_compose (
    input wire logic [1:0] method,
    input wire logic three_layer,
    input wire logic [5:0] flash,
    input wire logic flash_off,
    input wire logic [1:0] depth,
    input wire logic [3:0] l1,
    input wire logic [3:0] l2,
    input wire logic [3:0] l3,
    output logic [3:0] pix
);
    logic [3:0] m3;
    logic v1;
    logic v2;
    logic v3;
    logic blank_all;

    always_comb begin
        m3 = three_layer ? l3 : 4'h0;
        v1 = !(flash_off && (flash[1:0] != 2'h0));
        v2 = !(flash_off && (flash[3:2] != 2'h0));
        v3 = !(flash_off && (flash[5:4] != 2'h0));
        blank_all = !three_layer && flash_off &&
            ((flash == lcm_pkg::FLASH_BLANK_A) || (flash == lcm_pkg::FLASH_BLANK_B));
        pix = 4'h0;
        if (depth != lcm_pkg::DEPTH_1BPP) begin
            pix = l1;
        end else begin
            unique case (method)
                lcm_pkg::MIX_OR: pix = l1 | l2 | m3;
                lcm_pkg::MIX_XOR: pix = (l1 ^ l2) | m3;
                lcm_pkg::MIX_AND: pix = (l1 & l2) | m3;
                lcm_pkg::MIX_PRIORITY: begin
                    // With nothing blanked this returns the first nonzero layer, layer 1 first.
                    if (blank_all) begin
                        pix = 4'h0;
                    end else if (v1 && l1 != 4'h0) begin
                        pix = l1;
                    end else if (v2 && l2 != 4'h0) begin
                        pix = l2;
                    end else if (v3) begin
                        pix = m3;
                    end
                end
            endcase
        end
    end
endmodule

// ==== logic/lcm_core.sv ====
/*
 * Command interpreter and register file for layer composition, screen block modes,
 * glyph RAM base, dot shift, pixel depth and the memory pointer with its bursts.
 * Assumes a host command/data port and a register port on clk, and a display
 * memory that answers a read strobe with data in the next cycle.
 */
// Functional notes
// - Combine method selects OR, XOR, AND, priority.
// - Priority takes first nonzero layer when nothing flashes.
// - Flash attribute blanks layers in off phase, priority method at 1 bpp only.
// - Block mode bits choose text or graphics.
// - Second and fourth blocks always graphics.
// - Layer count bit selects two or three.
// - Glyph RAM base held as two bytes.
// - Dot shift 0 to 7 from low bits.
// - Dot shift applies to whole composed screen.
// - Depth field selects 1, 2, 4 bpp.
// - No overlay above one bit per pixel.
// - Sixteen-bit pointer set low then high.
// - Pointer changes only by setting or stepping.
// - Pointer is absolute, ignores scrolling.
// - Pointer read-back returns low then high.
// - Memory write stores then steps pointer.
// - Memory read prefetches, returns, steps, fetches.
// - Cursor shown two positions ahead while reading.
// - Step by one, minus one, pitch or minus pitch.
// - Overlay register holds count, modes, method.
`timescale 1ns/1ps
module lcm_core (
    input wire logic clk,
    input wire logic rst_n,

    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,

    input wire logic [7:0] host_wdata,
    input wire logic host_cmd_we,
    input wire logic host_data_we,
    input wire logic host_data_re,
    output logic [7:0] host_rdata,

    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    output logic mem_re,
    input wire logic [7:0] mem_rdata,

    input wire logic [3:0] layer1_pix,
    input wire logic [3:0] layer2_pix,
    input wire logic [3:0] layer3_pix,
    input wire logic flash_off,
    output logic [3:0] pix_out,

    output logic [3:0] block_graphics,
    output logic three_layer,
    output logic [1:0] pixel_depth,
    output logic [2:0] dot_shift,
    output logic [15:0] glyph_ram_base,
    output logic [15:0] cursor_addr
);

    typedef struct packed {
        lcm_pkg::lcm_ctx_t ctx;
        logic pidx;

        logic [7:0] step_dir;
        logic [7:0] overlay;
        logic [7:0] cg_low;
        logic [7:0] cg_high;
        logic [7:0] shift;
        logic [7:0] depth;
        logic [7:0] pitch_low;
        logic [7:0] pitch_high;
        logic [7:0] flash;

        logic [15:0] ptr;
        logic [7:0] obuf;
        logic fetch_pend;

        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
        logic mem_we;
        logic mem_re;
        logic [7:0] host_rdata;
        logic [7:0] reg_rdata;

        logic [3:0] pix;
        logic [3:0] blk_gfx;
        logic [15:0] cursor;
    } lcm_state_t;

    localparam lcm_state_t LCM_RESET = '{
        ctx: lcm_pkg::LCM_CTX_NONE,
        pidx: 1'b0,

        step_dir: lcm_pkg::RST_BYTE,
        overlay: lcm_pkg::RST_BYTE,
        cg_low: lcm_pkg::RST_BYTE,
        cg_high: lcm_pkg::RST_BYTE,
        shift: lcm_pkg::RST_BYTE,
        depth: lcm_pkg::RST_BYTE,
        pitch_low: lcm_pkg::RST_PITCH,
        pitch_high: lcm_pkg::RST_BYTE,
        flash: lcm_pkg::RST_BYTE,

        ptr: 16'h0000,
        obuf: lcm_pkg::RST_BYTE,
        fetch_pend: 1'b0,

        mem_addr: 16'h0000,
        mem_wdata: lcm_pkg::RST_BYTE,
        mem_we: 1'b0,
        mem_re: 1'b0,
        host_rdata: lcm_pkg::RST_BYTE,
        reg_rdata: lcm_pkg::RST_BYTE,

        pix: 4'h0,
        blk_gfx: 4'b1010,
        cursor: 16'h0000
    };

    lcm_state_t st;
    lcm_state_t next_st;
    logic [15:0] ptr_step;
    logic [15:0] cursor_step;
    logic [3:0] pix_mix;

    function automatic lcm_pkg::lcm_ctx_t cmd_ctx(input logic [7:0] cmd);
        lcm_pkg::lcm_ctx_t c;

        c = lcm_pkg::LCM_CTX_NONE;
        unique case (cmd)
            lcm_pkg::CMD_OVERLAY: c = lcm_pkg::LCM_CTX_OVERLAY;
            lcm_pkg::CMD_GLYPH_RAM_OFFSET: c = lcm_pkg::LCM_CTX_GLYPH;
            lcm_pkg::CMD_DOT_SHIFT: c = lcm_pkg::LCM_CTX_SHIFT;
            lcm_pkg::CMD_SET_POINTER: c = lcm_pkg::LCM_CTX_SET_PTR;
            lcm_pkg::CMD_READ_POINTER: c = lcm_pkg::LCM_CTX_READ_PTR;
            lcm_pkg::CMD_MEMORY_WRITE: c = lcm_pkg::LCM_CTX_MEM_WRITE;
            lcm_pkg::CMD_MEMORY_READ: c = lcm_pkg::LCM_CTX_MEM_READ;
            lcm_pkg::CMD_PIXEL_DEPTH: c = lcm_pkg::LCM_CTX_DEPTH;
            // Direction and unknown bytes take no parameters.
            default: c = lcm_pkg::LCM_CTX_NONE;
        endcase
        return c;
    endfunction

    function automatic logic [3:0] block_modes(input logic [7:0] ovl);
        // Blocks two and four carry graphics whatever the mode bits say.
        return {1'b1, ovl[lcm_pkg::OVL_BLOCK3_MODE], 1'b1, ovl[lcm_pkg::OVL_BLOCK1_MODE]};
    endfunction

    // One automatic step of the pointer.
    lcm_step u_step (
        .ptr(st.ptr),
        .dir(st.step_dir[1:0]),
        .pitch({st.pitch_high, st.pitch_low}),
        .next_ptr(ptr_step)
    );

    // The cursor runs one step ahead of the pointer in a read burst.
    lcm_step u_cursor_step (
        .ptr(st.cursor),
        .dir(st.step_dir[1:0]),
        .pitch({st.pitch_high, st.pitch_low}),
        .next_ptr(cursor_step)
    );

    // The composed pixel is registered one cycle after its inputs.
    lcm_compose u_compose (
        .method(st.overlay[1:0]),
        .three_layer(st.overlay[lcm_pkg::OVL_LAYER_COUNT]),
        .flash(st.flash[5:0]),
        .flash_off(flash_off),
        .depth(st.depth[1:0]),
        .l1(layer1_pix),
        .l2(layer2_pix),
        .l3(layer3_pix),
        .pix(pix_mix)
    );

    always_comb begin
        next_st = st;
        // Memory strobes are one-cycle pulses.
        next_st.mem_we = 1'b0;
        next_st.mem_re = 1'b0;
        // Memory data stands the cycle after the strobe; capture then.
        next_st.fetch_pend = st.mem_re;
        // Register read data stands for one cycle only.
        next_st.reg_rdata = lcm_pkg::RST_BYTE;
        next_st.pix = pix_mix;

        // A fetch issued last cycle lands in the bus buffer now.
        if (st.fetch_pend) begin
            next_st.obuf = mem_rdata;
        end

        if (host_cmd_we) begin
            // Any command byte closes the running burst.
            next_st.ctx = cmd_ctx(host_wdata);
            next_st.pidx = 1'b0;

            // Direction commands also set the step direction register.
            if (host_wdata[7:2] == lcm_pkg::CMD_DIR_BASE) begin
                next_st.step_dir = {6'h00, host_wdata[1:0]};
            end

            // The command wins over a fetch landing in the same cycle.
            if (host_wdata == lcm_pkg::CMD_READ_POINTER) begin
                next_st.obuf = st.ptr[7:0];
            end

            if (host_wdata == lcm_pkg::CMD_MEMORY_READ) begin
                next_st.mem_addr = st.ptr;
                next_st.mem_re = 1'b1;
            end
        end else if (host_data_we) begin
            // The first parameter goes to a low byte, later ones high.
            next_st.pidx = 1'b1;
            unique case (st.ctx)
                lcm_pkg::LCM_CTX_OVERLAY: next_st.overlay = {3'h0, host_wdata[4:0]};
                lcm_pkg::LCM_CTX_GLYPH: begin
                    if (!st.pidx) begin
                        next_st.cg_low = host_wdata;
                    end else begin
                        next_st.cg_high = host_wdata;
                    end
                end

                lcm_pkg::LCM_CTX_SHIFT: next_st.shift = {5'h00, host_wdata[2:0]};
                lcm_pkg::LCM_CTX_DEPTH: next_st.depth = {6'h00, host_wdata[1:0]};
                lcm_pkg::LCM_CTX_SET_PTR: begin
                    if (!st.pidx) begin
                        next_st.ptr[7:0] = host_wdata;
                    end else begin
                        next_st.ptr[15:8] = host_wdata;
                    end
                end

                lcm_pkg::LCM_CTX_MEM_WRITE: begin
                    next_st.mem_addr = st.ptr;
                    next_st.mem_wdata = host_wdata;
                    next_st.mem_we = 1'b1;
                    next_st.ptr = ptr_step;
                end

                default: next_st.pidx = st.pidx;
            endcase
        end else if (host_data_re) begin
            next_st.host_rdata = st.obuf;

            if (st.ctx == lcm_pkg::LCM_CTX_READ_PTR) begin
                next_st.obuf = st.ptr[15:8];
            end else if (st.ctx == lcm_pkg::LCM_CTX_MEM_READ) begin
                next_st.ptr = ptr_step;
                next_st.mem_addr = ptr_step;
                next_st.mem_re = 1'b1;
            end
        end else if (reg_we) begin
            // A host byte in the same cycle takes priority.
            unique case (reg_addr)
                lcm_pkg::OFS_STEP_DIR: next_st.step_dir = {6'h00, reg_wdata[1:0]};
                lcm_pkg::OFS_OVERLAY: next_st.overlay = {3'h0, reg_wdata[4:0]};
                lcm_pkg::OFS_CG_LOW: next_st.cg_low = reg_wdata;
                lcm_pkg::OFS_CG_HIGH: next_st.cg_high = reg_wdata;
                lcm_pkg::OFS_DOT_SHIFT: next_st.shift = {5'h00, reg_wdata[2:0]};
                lcm_pkg::OFS_PTR_WR_LOW: next_st.ptr[7:0] = reg_wdata;
                lcm_pkg::OFS_PTR_WR_HIGH: next_st.ptr[15:8] = reg_wdata;

                lcm_pkg::OFS_DEPTH: next_st.depth = {6'h00, reg_wdata[1:0]};
                lcm_pkg::OFS_PITCH_LOW: next_st.pitch_low = reg_wdata;
                lcm_pkg::OFS_PITCH_HIGH: next_st.pitch_high = reg_wdata;
                lcm_pkg::OFS_FLASH: next_st.flash = {2'h0, reg_wdata[5:0]};
                default: next_st.pidx = st.pidx;
            endcase
        end

        if (reg_re) begin
            unique case (reg_addr)
                lcm_pkg::OFS_STEP_DIR: next_st.reg_rdata = st.step_dir;
                lcm_pkg::OFS_OVERLAY: next_st.reg_rdata = st.overlay;
                lcm_pkg::OFS_CG_LOW: next_st.reg_rdata = st.cg_low;
                lcm_pkg::OFS_CG_HIGH: next_st.reg_rdata = st.cg_high;
                lcm_pkg::OFS_DOT_SHIFT: next_st.reg_rdata = st.shift;
                lcm_pkg::OFS_PTR_WR_LOW: next_st.reg_rdata = st.ptr[7:0];
                lcm_pkg::OFS_PTR_WR_HIGH: next_st.reg_rdata = st.ptr[15:8];
                lcm_pkg::OFS_PTR_RD_LOW: next_st.reg_rdata = st.ptr[7:0];
                lcm_pkg::OFS_PTR_RD_HIGH: next_st.reg_rdata = st.ptr[15:8];

                lcm_pkg::OFS_DEPTH: next_st.reg_rdata = st.depth;
                lcm_pkg::OFS_PITCH_LOW: next_st.reg_rdata = st.pitch_low;
                lcm_pkg::OFS_PITCH_HIGH: next_st.reg_rdata = st.pitch_high;
                lcm_pkg::OFS_FLASH: next_st.reg_rdata = st.flash;
                default: next_st.reg_rdata = lcm_pkg::RST_BYTE;
            endcase
        end

        next_st.blk_gfx = block_modes(next_st.overlay);

        // While reading, the pointer sits one ahead of the returned byte,
        // and the cursor one step further.
        if (next_st.ctx == lcm_pkg::LCM_CTX_MEM_READ) begin
            if (st.ctx == lcm_pkg::LCM_CTX_MEM_READ && host_data_re && !host_cmd_we && !host_data_we) begin
                next_st.cursor = cursor_step;
            end else begin
                next_st.cursor = ptr_step;
            end
        end else begin
            next_st.cursor = next_st.ptr;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= LCM_RESET;
        end else begin
            st <= next_st;
        end
    end

    // All outputs come straight from the state register.
    assign reg_rdata = st.reg_rdata;
    assign host_rdata = st.host_rdata;

    assign mem_addr = st.mem_addr;
    assign mem_wdata = st.mem_wdata;
    assign mem_we = st.mem_we;
    assign mem_re = st.mem_re;

    assign pix_out = st.pix;

    assign block_graphics = st.blk_gfx;
    assign three_layer = st.overlay[lcm_pkg::OVL_LAYER_COUNT];
    assign pixel_depth = st.depth[1:0];
    assign dot_shift = st.shift[2:0];
    assign glyph_ram_base = {st.cg_high, st.cg_low};
    assign cursor_addr = st.cursor;
endmodule

// ==== tb/lcm_chk.sv ====
/* Port checker for lcm_core, bound to every instance.
   Assumes one clock domain with an asynchronous active-low reset. */
`timescale 1ns/1ps
module lcm_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] reg_addr,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] host_wdata,
    input wire logic host_cmd_we,
    input wire logic host_data_we,
    input wire logic host_data_re,
    input wire logic [7:0] host_rdata,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    input wire logic mem_re,
    input wire logic [3:0] block_graphics,
    input wire logic three_layer,
    input wire logic [1:0] pixel_depth,
    input wire logic [2:0] dot_shift,
    input wire logic [15:0] cursor_addr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire quiet = !host_cmd_we && !host_data_we && !host_data_re;
    wire rd_q = reg_re && quiet;
    a_blocks_graphics: assert property (block_graphics[1] && block_graphics[3])
        else $error("block two or four not graphics");
    a_shift_readback: assert property (rd_q && reg_addr == lcm_pkg::OFS_DOT_SHIFT
        |=> reg_rdata == {5'h00, dot_shift}) else $error("dot shift readback wrong");
    a_depth_readback: assert property (rd_q && reg_addr == lcm_pkg::OFS_DEPTH
        |=> reg_rdata == {6'h00, pixel_depth}) else $error("depth readback wrong");
    a_overlay_readback: assert property (rd_q && reg_addr == lcm_pkg::OFS_OVERLAY
        |=> reg_rdata[7:2] == {3'h0, three_layer, block_graphics[2], block_graphics[0]})
        else $error("overlay readback wrong");
    a_write_data: assert property (mem_we |-> $past(host_data_we) && mem_wdata == $past(host_wdata))
        else $error("memory write without host byte");
    a_pointer_hold: assert property ($past(quiet) && !$past(reg_we) |-> $stable(cursor_addr))
        else $error("pointer moved without cause");
    a_rdata_hold: assert property (!$past(host_data_re) |-> $stable(host_rdata))
        else $error("host read data changed without read");
    a_fetch_cause: assert property (mem_re |-> $past(host_data_re) || $past(host_cmd_we))
        else $error("memory fetch without cause");
    c_mem_write: cover property (mem_we);
    c_mem_read: cover property (mem_re);
    c_deep_pixels: cover property (pixel_depth != lcm_pkg::DEPTH_1BPP);
endmodule
bind lcm_core lcm_chk i_lcm_chk (.clk, .rst_n, .reg_addr, .reg_we, .reg_re, .reg_rdata, .host_wdata,
    .host_cmd_we, .host_data_we, .host_data_re, .host_rdata, .mem_wdata, .mem_we, .mem_re,
    .block_graphics, .three_layer, .pixel_depth, .dot_shift, .cursor_addr);

// ==== tb/lcm_mem_model.sv ====
/* Display memory model: stores writes, answers a read one cycle later.
   Assumes the core's clock; the data line changes every idle cycle. */
`timescale 1ns/1ps
module lcm_mem_model (
    input wire logic clk,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    input wire logic mem_re,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    int n_writes = 0;
    initial mem_rdata = 8'h5a;
    always @(posedge clk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
            n_writes <= n_writes + 1;
        end
        mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
    end
endmodule

// ==== tb/tb.sv ====
/* Self-checking bench for lcm_core with a display memory model.
   Assumes lcm_chk is bound to the core and a 250 MHz clock. */
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [7:0] host_wdata = 8'h00;
    logic host_cmd_we = 1'b0;
    logic host_data_we = 1'b0;
    logic host_data_re = 1'b0;
    logic [3:0] l1 = 4'h0;
    logic [3:0] l2 = 4'h0;
    logic [3:0] l3 = 4'h0;
    logic flash_off = 1'b0;
    logic [7:0] reg_rdata, host_rdata, mem_wdata, mem_rdata;
    logic [15:0] mem_addr, glyph_ram_base, cursor_addr;
    logic mem_we, mem_re, three_layer;
    logic [3:0] pix_out, block_graphics;
    logic [1:0] pixel_depth;
    logic [2:0] dot_shift;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    lcm_core i_lcm_core (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .host_wdata,
        .host_cmd_we, .host_data_we, .host_data_re, .host_rdata, .mem_addr, .mem_wdata, .mem_we, .mem_re,
        .mem_rdata, .layer1_pix(l1), .layer2_pix(l2), .layer3_pix(l3), .flash_off, .pix_out,
        .block_graphics, .three_layer, .pixel_depth, .dot_shift, .glyph_ram_base, .cursor_addr);
    lcm_mem_model i_lcm_mem_model (.clk, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata);
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    task automatic hput(input logic cmd, input logic [7:0] b);
        @(posedge clk);
        host_wdata <= b;
        host_cmd_we <= cmd;
        host_data_we <= !cmd;
        @(posedge clk);
        host_cmd_we <= 1'b0;
        host_data_we <= 1'b0;
        #1;
    endtask
    task automatic hchk(input logic [7:0] e);
        @(posedge clk);
        host_data_re <= 1'b1;
        @(posedge clk);
        host_data_re <= 1'b0;
        #1;
        chk(host_rdata, e);
    endtask
    task automatic setp(input logic [15:0] p);
        hput(1'b1, lcm_pkg::CMD_SET_POINTER);
        hput(1'b0, p[7:0]);
        hput(1'b0, p[15:8]);
    endtask
    task automatic pchk(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c, input logic f,
        input logic [3:0] e);
        @(posedge clk);
        l1 <= a;
        l2 <= b;
        l3 <= c;
        flash_off <= f;
        @(posedge clk);
        #1;
        chk(pix_out, e);
    endtask
    task automatic t_reset();
        logic [15:0] a;
        chk(block_graphics, 4'b1010);
        for (int i = 0; i < 14; i++) begin
            a = 16'h8017 + 16'(i);
            rchk(a, (a == 16'h8021) ? lcm_pkg::RST_PITCH : lcm_pkg::RST_BYTE);
        end
    endtask
    task automatic t_regs();
        reg_wr(16'h8019, 8'ha5);
        reg_wr(16'h801a, 8'h3c);
        reg_wr(16'h801b, 8'hff);
        reg_wr(16'h801c, 8'h12);
        reg_wr(16'h801d, 8'h34);
        reg_wr(16'h8020, 8'hff);
        reg_wr(16'h801e, 8'h00);
        chk(glyph_ram_base, 16'h3ca5);
        rchk(16'h801b, 8'h07);
        chk(dot_shift, 3'h7);
        rchk(16'h8020, 8'h03);
        rchk(16'h801e, 8'h12);
        rchk(16'h801f, 8'h34);
        chk(cursor_addr, 16'h3412);
        reg_wr(16'h8020, 8'h00);
    endtask
    task automatic t_overlay();
        logic [3:0] e [4] = '{4'hf, 4'he, 4'h9, 4'h5};
        hput(1'b1, lcm_pkg::CMD_OVERLAY);
        hput(1'b0, 8'h04);
        chk(block_graphics, 4'b1011);
        rchk(16'h8018, 8'h04);
        hput(1'b0, 8'h08);
        chk(block_graphics, 4'b1110);
        for (int m = 0; m < 4; m++) begin
            hput(1'b0, 8'h1c | 8'(m));
            chk(three_layer, 1'b1);
            pchk(4'h5, 4'h3, 4'h8, 1'b0, e[m]);
        end
        for (int v = 0; v < 8; v++) begin
            pchk(4'(v & 1), 4'((v >> 1) & 1), 4'(v >> 2), 1'b1, 4'(v != 0));
        end
        reg_wr(16'h8023, 8'h01);
        pchk(4'h5, 4'h3, 4'h8, 1'b1, 4'h3);
        pchk(4'h5, 4'h3, 4'h8, 1'b0, 4'h5);
        hput(1'b1, lcm_pkg::CMD_OVERLAY);
        hput(1'b0, 8'h07);
        reg_wr(16'h8023, 8'h20);
        pchk(4'h5, 4'h3, 4'h8, 1'b1, 4'h0);
        reg_wr(16'h8023, 8'h30);
        pchk(4'h5, 4'h3, 4'h8, 1'b1, 4'h0);
        hput(1'b0, 8'h00);
        pchk(4'h5, 4'h3, 4'h8, 1'b1, 4'h7);
        hput(1'b1, lcm_pkg::CMD_PIXEL_DEPTH);
        hput(1'b0, 8'h02);
        chk(pixel_depth, 2'h2);
        pchk(4'h5, 4'h3, 4'h8, 1'b0, 4'h5);
        hput(1'b0, 8'h00);
    endtask
    task automatic t_params();
        hput(1'b1, lcm_pkg::CMD_GLYPH_RAM_OFFSET);
        hput(1'b0, 8'h00);
        hput(1'b0, 8'h48);
        chk(glyph_ram_base, 16'h4800);
        hput(1'b1, lcm_pkg::CMD_DOT_SHIFT);
        hput(1'b0, 8'h0d);
        chk(dot_shift, 3'h5);
        setp(16'h1000);
        chk(cursor_addr, 16'h1000);
        hput(1'b1, lcm_pkg::CMD_READ_POINTER);
        hchk(8'h00);
        hchk(8'h10);
    endtask
    task automatic t_write();
        logic [15:0] s [4] = '{16'h0001, 16'hffff, 16'hffd8, 16'h0028};
        int n;
        for (int d = 0; d < 4; d++) begin
            hput(1'b1, {lcm_pkg::CMD_DIR_BASE, 2'(d)});
            setp(16'h1000);
            hput(1'b1, lcm_pkg::CMD_MEMORY_WRITE);
            hput(1'b0, 8'h10 + 8'(d));
            hput(1'b0, 8'h20 + 8'(d));
            repeat (2) @(posedge clk);
            chk(i_lcm_mem_model.mem[16'h1000], 8'h10 + 8'(d));
            chk(i_lcm_mem_model.mem[16'h1000 + s[d]], 8'h20 + 8'(d));
            chk(cursor_addr, 16'h1000 + s[d] + s[d]);
        end
        n = i_lcm_mem_model.n_writes;
        hput(1'b1, lcm_pkg::CMD_DOT_SHIFT);
        hput(1'b0, 8'h02);
        hput(1'b1, 8'h4c);
        hput(1'b0, 8'h55);
        repeat (2) @(posedge clk);
        chk(dot_shift, 3'h2);
        chk(16'(i_lcm_mem_model.n_writes - n), 16'h0000);
        chk(cursor_addr, 16'h1050);
    endtask
    task automatic t_read();
        for (int k = 0; k < 3; k++) begin
            i_lcm_mem_model.mem[16'h2000 + 16'(k)] = 8'hc0 + 8'(k);
        end
        setp(16'h2000);
        hput(1'b1, lcm_pkg::CMD_MEMORY_READ);
        for (int k = 0; k < 3; k++) begin
            repeat (3) @(posedge clk);
            hchk(8'hc0 + 8'(k));
            chk(cursor_addr, 16'h2002 + 16'(k));
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_overlay();
        t_params();
        t_write();
        t_read();
        results();
    end
endmodule
